//--- qos_pkg.sv
/*
 Shared constants, register map and carrier types for the frame-buffer
 admission and QoS block. Assumes a 200 MHz system clock.
*/
package qos_pkg;
  localparam int NPORT = 10;
  localparam int NACC = 8;
  localparam int NQ = 4;
  localparam int CW = 12;
  localparam logic [3:0] CPU_PORT = 4'h8;
  localparam logic [3:0] UPLINK_PORT = 4'h9;
  // Shaper: setting/64 of the 1000 Mbps line
  localparam int SHAPE_DEN = 64;
  localparam int LINE_MBPS = 1000;
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHAPE = 8'h04;
  localparam logic [7:0] OFS_CLASS = 8'h14;
  localparam logic [7:0] OFS_SHARED = 8'h20;
  localparam logic [7:0] OFS_ACC = 8'h24;
  localparam logic [7:0] OFS_CPU = 8'h28;
  localparam logic [7:0] OFS_UP = 8'h2C;
  localparam logic [7:0] OFS_XOFF = 8'h30;
  localparam logic [7:0] OFS_PKT = 8'h34;
  localparam logic [7:0] OFS_MCC = 8'h38;
  localparam logic [7:0] OFS_MCH = 8'h3C;
  localparam logic [7:0] OFS_MCP = 8'h40;
  localparam logic [7:0] OFS_PROB = 8'h44;
  localparam logic [7:0] OFS_LOW = 8'h48;
  localparam logic [7:0] OFS_TEMP = 8'h4C;
  localparam logic [7:0] OFS_RATE = 8'h60;
  localparam logic [7:0] OFS_ST_SHARED = 8'h80;
  localparam logic [7:0] OFS_ST_MC = 8'h84;
  localparam logic [7:0] OFS_ST_PAUSE = 8'h88;
  localparam logic [7:0] OFS_ST_DROPS = 8'h8C;
  localparam logic [7:0] OFS_ST_SRC = 8'hC0;
  // Field positions
  localparam int CTRL_PAUSE_LSB = 16;
  localparam int RATE_TX_LSB = 8;
  localparam int RATE_BURST_LSB = 16;
  // Reset values
  localparam logic [CW-1:0] TEMP_RST = 12'h010;
  localparam logic [CW-1:0] SHARED_RST = 12'h040;
  localparam logic [CW-1:0] RES_RST = 12'h008;

  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_CLASS = 2'b01,
    REG_SHARED = 2'b10,
    REG_SOURCE = 2'b11
  } region_type;

  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [2:0] prio;
    logic mcast;
    logic [CW-1:0] qdepth;
  } cls_type;

  typedef struct packed {
    logic valid;
    logic drop;
    region_type region;
    logic [1:0] queue;
  } adm_type;

  typedef struct packed {
    logic valid;
    region_type region;
    logic [3:0] src;
    logic [2:0] prio;
    logic mcast;
  } rel_type;

  typedef struct packed {
    logic [3:0] shape_en;
    logic [NPORT-1:0] pause_en;
    logic [NQ-1:0][6:0] shape_rate;
    logic [2:0][CW-1:0] class_res;
    logic [CW-1:0] shared_size;
    logic [CW-1:0] acc_res;
    logic [CW-1:0] cpu_res;
    logic [CW-1:0] up_res;
    logic [CW-1:0] xoff_level;
    logic [CW-1:0] pkt_congest;
    logic [CW-1:0] mc_congest;
    logic [CW-1:0] mc_hard;
    logic [CW-1:0] mc_pause;
    logic [CW-1:0] low_thresh;
    logic [CW-1:0] temp_size;
    logic [7:0] drop_prob;
    logic [NACC-1:0][31:0] rate_cfg;
  } cfg_type;
endpackage

//--- buffer_qos.sv
/*
 Frame-buffer admission, drop decision, pause triggering, uplink queue
 shaping and access-port rate control. Assumes all inputs synchronous
 to sys_clk and a one-cycle-latency register port.
*/
`timescale 1ns/1ps
// Behaviour
// - Every uplink queue shaped, shaped means strict
// - Shaped rate is setting/64 of 1000 Mbps
// - Shaped queues keep strict-priority order
// - Access ports limit rx and tx, burst
// - Arrivals held in temp region first
// - Three class reserves for pairs 2/3,4/5,6/7
// - Classes 0 and 1 get no reserve
// - Accounting keeps three class counters, one per pair
// - Ten source reservations, port 8 processor
// - Class, then shared, then source reservation
// - Best-effort drop when source lacks space
// - Congested, shared full: random drop
// - Congested, source below low: always drop
// - Multicast congest threshold: random drop
// - Multicast hard limit: always drop
// - Pause ports skip certain drops, keep random
// - Pause ports still classified, random drop
// - Xoff when programmed source slots used
// - Xon only when all source slots free
// - Multicast pause on global counter threshold
// - Queues map to diffserv classes
// - Pause-port traffic goes best effort
// - Lower queue only when higher empty or short of credit
module buffer_qos #(
  parameter int SHAPE_CAP = 128
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame admission
  input wire logic arr_valid,
  output logic arr_ok,
  input wire qos_pkg::cls_type cls,
  output qos_pkg::adm_type adm,
  input wire qos_pkg::rel_type rel,
  // Pause requests
  output logic [qos_pkg::NPORT-1:0] xoff,
  output logic mc_xoff,
  // Uplink scheduler
  input wire logic [qos_pkg::NQ-1:0] upq_nonempty,
  input wire logic sched_req,
  output logic [qos_pkg::NQ-1:0] upq_grant,
  // Access-port rate control
  input wire logic [qos_pkg::NACC-1:0] rx_use,
  input wire logic [qos_pkg::NACC-1:0] tx_use,
  output logic [qos_pkg::NACC-1:0] rx_allow,
  output logic [qos_pkg::NACC-1:0] tx_allow
);
  import qos_pkg::*;

  localparam logic [8:0] COST = 9'(SHAPE_DEN);
  localparam logic [8:0] CAP = 9'(SHAPE_CAP);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] base, input int i);
    return a == 8'(int'(base) + 4 * i);
  endfunction

  function automatic logic [1:0] qmap(input logic [2:0] p);
    return p[2:1];
  endfunction

  cfg_type cfg, next_cfg;
  logic [31:0] next_rdata;
  logic [CW-1:0] temp_used, next_temp;
  logic [2:0][CW-1:0] class_used, next_class;
  logic [CW-1:0] shared_used, next_shared;
  logic [NPORT-1:0][CW-1:0] src_used, next_src;
  logic [CW-1:0] mc_count, next_mc;
  logic [15:0] drop_cnt, next_drops;
  logic next_arr_ok;
  adm_type next_adm;
  logic [NPORT-1:0] next_xoff;
  logic next_mc_xoff;
  logic [NQ-1:0][8:0] credit, next_credit;
  logic [NQ-1:0] elig, next_grant;
  logic [7:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic [NACC-1:0][15:0] rx_cr, tx_cr, next_rx_cr, next_tx_cr;
  logic [NACC-1:0] next_rx_allow, next_tx_allow;
  logic [15:0] lfsr, next_lfsr;

  function automatic logic [CW-1:0] src_res(input logic [3:0] p,
                                            input cfg_type c);
    if (p == CPU_PORT) return c.cpu_res;
    if (p == UPLINK_PORT) return c.up_res;
    return c.acc_res;
  endfunction

  // Configuration and read-back
  always_comb begin
    next_cfg = cfg;
    next_rdata = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          next_cfg.shape_en = reg_wdata[3:0];
          next_cfg.pause_en = reg_wdata[CTRL_PAUSE_LSB +: NPORT];
        end
        OFS_SHARED: next_cfg.shared_size = reg_wdata[CW-1:0];
        OFS_ACC: next_cfg.acc_res = reg_wdata[CW-1:0];
        OFS_CPU: next_cfg.cpu_res = reg_wdata[CW-1:0];
        OFS_UP: next_cfg.up_res = reg_wdata[CW-1:0];
        OFS_XOFF: next_cfg.xoff_level = reg_wdata[CW-1:0];
        OFS_PKT: next_cfg.pkt_congest = reg_wdata[CW-1:0];
        OFS_MCC: next_cfg.mc_congest = reg_wdata[CW-1:0];
        OFS_MCH: next_cfg.mc_hard = reg_wdata[CW-1:0];
        OFS_MCP: next_cfg.mc_pause = reg_wdata[CW-1:0];
        OFS_PROB: next_cfg.drop_prob = reg_wdata[7:0];
        OFS_LOW: next_cfg.low_thresh = reg_wdata[CW-1:0];
        OFS_TEMP: next_cfg.temp_size = reg_wdata[CW-1:0];
        default: ;
      endcase
      for (int q = 0; q < NQ; q++) begin
        // Settings above 64 saturate at full line rate
        if (hit(reg_addr, OFS_SHAPE, q)) begin
          next_cfg.shape_rate[q] = (reg_wdata[6:0] > 7'h40) ?
                                   7'h40 : reg_wdata[6:0];
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (hit(reg_addr, OFS_CLASS, c)) begin
          next_cfg.class_res[c] = reg_wdata[CW-1:0];
        end
      end
      for (int p = 0; p < NACC; p++) begin
        if (hit(reg_addr, OFS_RATE, p)) begin
          next_cfg.rate_cfg[p] = reg_wdata;
        end
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: next_rdata = {6'h00, cfg.pause_en, 12'h000,
                                cfg.shape_en};
        OFS_SHARED: next_rdata = 32'(cfg.shared_size);
        OFS_ACC: next_rdata = 32'(cfg.acc_res);
        OFS_CPU: next_rdata = 32'(cfg.cpu_res);
        OFS_UP: next_rdata = 32'(cfg.up_res);
        OFS_XOFF: next_rdata = 32'(cfg.xoff_level);
        OFS_PKT: next_rdata = 32'(cfg.pkt_congest);
        OFS_MCC: next_rdata = 32'(cfg.mc_congest);
        OFS_MCH: next_rdata = 32'(cfg.mc_hard);
        OFS_MCP: next_rdata = 32'(cfg.mc_pause);
        OFS_PROB: next_rdata = 32'(cfg.drop_prob);
        OFS_LOW: next_rdata = 32'(cfg.low_thresh);
        OFS_TEMP: next_rdata = 32'(cfg.temp_size);
        OFS_ST_SHARED: next_rdata = 32'(shared_used);
        OFS_ST_MC: next_rdata = 32'(mc_count);
        OFS_ST_PAUSE: next_rdata = 32'({mc_xoff, xoff});
        OFS_ST_DROPS: next_rdata = 32'(drop_cnt);
        default: ;
      endcase
      for (int q = 0; q < NQ; q++) begin
        if (hit(reg_addr, OFS_SHAPE, q)) begin
          next_rdata = 32'(cfg.shape_rate[q]);
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (hit(reg_addr, OFS_CLASS, c)) begin
          next_rdata = 32'(cfg.class_res[c]);
        end
      end
      for (int p = 0; p < NACC; p++) begin
        if (hit(reg_addr, OFS_RATE, p)) begin
          next_rdata = cfg.rate_cfg[p];
        end
      end
      for (int p = 0; p < NPORT; p++) begin
        if (hit(reg_addr, OFS_ST_SRC, p)) begin
          next_rdata = 32'(src_used[p]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg <= '0;
      cfg.shared_size <= SHARED_RST;
      cfg.temp_size <= TEMP_RST;
      cfg.acc_res <= RES_RST;
      cfg.cpu_res <= RES_RST;
      cfg.up_res <= RES_RST;
      reg_rdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // Admission decision and buffer accounting
  logic [1:0] cp;
  logic class_ok, shared_ok, src_ok, congested, rnd, hard, rdrop;
  logic [CW-1:0] sres, sused;
  region_type region;
  always_comb begin
    cp = cls.prio[2:1];
    class_ok = (cp != 2'b00) &&
               (class_used[cp - 2'd1] < cfg.class_res[cp - 2'd1]);
    shared_ok = shared_used < cfg.shared_size;
    sres = src_res(cls.src, cfg);
    sused = src_used[cls.src];
    src_ok = sused < sres;
    congested = cls.qdepth >= cfg.pkt_congest;
    rnd = lfsr[7:0] < cfg.drop_prob;
    // Class first, then shared pool, then source reservation
    if (class_ok) region = REG_CLASS;
    else if (shared_ok) region = REG_SHARED;
    else if (src_ok) region = REG_SOURCE;
    else region = REG_NONE;
    next_adm.valid = cls.valid;
    next_adm.region = region;
    next_adm.queue = cfg.pause_en[cls.src] ? 2'b00 :
                     qmap(cls.prio);
    hard = 1'b0;
    rdrop = 1'b0;
    if (cls.mcast) begin
      if (mc_count >= cfg.mc_hard) hard = 1'b1;
      else if (mc_count >= cfg.mc_congest) rdrop = rnd;
    end else if (next_adm.queue == 2'b00) begin
      if (!src_ok) hard = 1'b1;
      if (congested && !shared_ok) rdrop = rnd;
      if (congested && (!src_ok || (sres - sused) < cfg.low_thresh)) begin
        hard = 1'b1;
      end
    end
    // No slot at all cannot be stored, pause or not
    next_adm.drop = cls.valid && ((hard && !cfg.pause_en[cls.src]) ||
                    rdrop || region == REG_NONE);
    next_arr_ok = temp_used < cfg.temp_size;
    next_temp = temp_used;
    if (arr_valid && next_arr_ok) next_temp = next_temp + 1'b1;
    if (cls.valid && temp_used != '0) next_temp = next_temp - 1'b1;
    next_class = class_used;
    next_shared = shared_used;
    next_src = src_used;
    next_mc = mc_count;
    next_drops = drop_cnt;
    if (cls.valid && next_adm.drop) next_drops = drop_cnt + 1'b1;
    if (cls.valid && !next_adm.drop) begin
      case (region)
        REG_CLASS: next_class[cp - 2'd1] = class_used[cp - 2'd1] + 1'b1;
        REG_SHARED: next_shared = shared_used + 1'b1;
        REG_SOURCE: next_src[cls.src] = sused + 1'b1;
        default: ;
      endcase
      if (cls.mcast) next_mc = mc_count + 1'b1;
    end
    if (rel.valid) begin
      case (rel.region)
        REG_CLASS: begin
          if (rel.prio[2:1] != 2'b00) begin
            next_class[rel.prio[2:1] - 2'd1] =
              next_class[rel.prio[2:1] - 2'd1] - 1'b1;
          end
        end
        REG_SHARED: next_shared = next_shared - 1'b1;
        REG_SOURCE: next_src[rel.src] = next_src[rel.src] - 1'b1;
        default: ;
      endcase
      if (rel.mcast) next_mc = next_mc - 1'b1;
    end
    for (int p = 0; p < NPORT; p++) begin
      // Xon waits for every reserved slot to be freed
      if (xoff[p]) next_xoff[p] = src_used[p] != '0;
      else next_xoff[p] = cfg.pause_en[p] && cfg.xoff_level != '0 &&
                          src_used[p] >= cfg.xoff_level;
    end
    next_mc_xoff = mc_count > cfg.mc_pause;
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      temp_used <= '0;
      class_used <= '0;
      shared_used <= '0;
      src_used <= '0;
      mc_count <= '0;
      drop_cnt <= 16'h0000;
      arr_ok <= 1'b0;
      adm <= '0;
      xoff <= '0;
      mc_xoff <= 1'b0;
      lfsr <= 16'hACE1;
    end else begin
      temp_used <= next_temp;
      class_used <= next_class;
      shared_used <= next_shared;
      src_used <= next_src;
      mc_count <= next_mc;
      drop_cnt <= next_drops;
      arr_ok <= next_arr_ok;
      adm <= next_adm;
      xoff <= next_xoff;
      mc_xoff <= next_mc_xoff;
      lfsr <= next_lfsr;
    end
  end

  // Uplink shaper: credit earns setting per cycle, a unit costs 64
  always_comb begin
    next_grant = '0;
    for (int q = 0; q < NQ; q++) begin
      elig[q] = upq_nonempty[q] &&
                (!cfg.shape_en[q] || credit[q] >= COST);
    end
    // Highest queue first, shaped or not
    for (int q = 0; q < NQ; q++) begin
      if (sched_req && elig[q]) next_grant = NQ'(1) << q;
    end
    for (int q = 0; q < NQ; q++) begin
      next_credit[q] = credit[q];
      if (cfg.shape_en[q]) begin
        next_credit[q] = credit[q] + 9'(cfg.shape_rate[q]);
        if (next_credit[q] > CAP) next_credit[q] = CAP;
        if (next_grant[q]) next_credit[q] = next_credit[q] - COST;
      end else begin
        next_credit[q] = 9'h000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      credit <= '0;
      upq_grant <= '0;
    end else begin
      credit <= next_credit;
      upq_grant <= next_grant;
    end
  end

  // Access-port rate control, refilled once per microsecond
  always_comb begin
    tick = tick_cnt == TICK_LAST;
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 1'b1;
    for (int p = 0; p < NACC; p++) begin
      next_rx_cr[p] = rx_cr[p];
      next_tx_cr[p] = tx_cr[p];
      if (tick) begin
        next_rx_cr[p] = rx_cr[p] + 16'(cfg.rate_cfg[p][7:0]);
        next_tx_cr[p] = tx_cr[p] +
                        16'(cfg.rate_cfg[p][RATE_TX_LSB +: 8]);
      end
      // Burst caps the saved credit
      if (next_rx_cr[p] > cfg.rate_cfg[p][RATE_BURST_LSB +: 16]) begin
        next_rx_cr[p] = cfg.rate_cfg[p][RATE_BURST_LSB +: 16];
      end
      if (next_tx_cr[p] > cfg.rate_cfg[p][RATE_BURST_LSB +: 16]) begin
        next_tx_cr[p] = cfg.rate_cfg[p][RATE_BURST_LSB +: 16];
      end
      if (rx_use[p] && next_rx_cr[p] != 16'h0000) begin
        next_rx_cr[p] = next_rx_cr[p] - 1'b1;
      end
      if (tx_use[p] && next_tx_cr[p] != 16'h0000) begin
        next_tx_cr[p] = next_tx_cr[p] - 1'b1;
      end
      next_rx_allow[p] = next_rx_cr[p] != 16'h0000;
      next_tx_allow[p] = next_tx_cr[p] != 16'h0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick_cnt <= 8'h00;
      rx_cr <= '0;
      tx_cr <= '0;
      rx_allow <= '0;
      tx_allow <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      rx_cr <= next_rx_cr;
      tx_cr <= next_tx_cr;
      rx_allow <= next_rx_allow;
      tx_allow <= next_tx_allow;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence mc_full_s;
    cls.valid && cls.mcast && mc_count >= cfg.mc_hard &&
    !cfg.pause_en[cls.src];
  endsequence

  AST_SP_ORDER: assert property (
    upq_grant[0] |-> $past(sched_req) && $past(elig[3:1]) == 3'b000)
    else $error("lower queue granted over a higher one");
  AST_SHAPE_CREDIT: assert property (
    upq_grant[1] && $past(cfg.shape_en[1]) |-> $past(credit[1]) >= COST)
    else $error("shaped queue granted without credit");
  AST_MC_HARD: assert property (mc_full_s |=> adm.drop)
    else $error("multicast over hard limit not dropped");
  AST_BE_NOSPACE: assert property (
    cls.valid && !cls.mcast && next_adm.queue == 2'b00 && !src_ok &&
    !cfg.pause_en[cls.src] |=> adm.valid && adm.drop)
    else $error("best-effort frame kept without source space");
  AST_CLASS_FIRST: assert property (
    cls.valid && class_ok |=> adm.region == REG_CLASS)
    else $error("class section skipped");
  AST_LOW_CLASS: assert property (
    cls.valid && cls.prio[2:1] == 2'b00 |=> adm.region != REG_CLASS)
    else $error("low class used a class reserve");
  AST_PAUSE_BE: assert property (
    cls.valid && cfg.pause_en[cls.src] |=> adm.queue == 2'b00)
    else $error("pause-port frame not best effort");
  // Every port watched, not just one that may never pause
  for (genvar p = 0; p < NPORT; p++) begin : pause_chk
    AST_XON: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $fell(xoff[p]) |-> $past(src_used[p]) == '0)
      else $error("xon before all source slots free");
    AST_XOFF: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !xoff[p] && cfg.pause_en[p] && cfg.xoff_level != '0 &&
      src_used[p] >= cfg.xoff_level |=> xoff[p])
      else $error("xoff not raised at level");
  end
  AST_MC_XOFF: assert property (
    mc_count > cfg.mc_pause |=> mc_xoff)
    else $error("multicast pause not raised");
  AST_MC_XON: assert property (
    mc_count <= cfg.mc_pause |=> !mc_xoff)
    else $error("multicast pause not released");
endmodule

//--- queue_side.sv
/*
 Uplink egress queue model: frame count per queue, one frame leaves on
 each grant. Assumes one-hot grants synchronous to sys_clk.
*/
`timescale 1ns/1ps
module queue_side (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Frame loading
  input wire logic load_valid,
  input wire logic [1:0] load_q,
  // Scheduler side
  input wire logic [qos_pkg::NQ-1:0] upq_grant,
  output logic [qos_pkg::NQ-1:0] upq_nonempty
);
  import qos_pkg::*;
  logic [NQ-1:0][2:0] count;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      for (int i = 0; i < NQ; i++) begin
        count[i] <= count[i] + 3'(load_valid && load_q == 2'(i))
          - 3'(upq_grant[i] && count[i] != 3'h0);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      upq_nonempty[i] = count[i] != 3'h0;
    end
  end
endmodule

//--- frame_buffer_admission_qos_tb.sv
/*
 Self-checking bench for buffer_qos: register port, admission, pause,
 scheduler and rate control. Assumes queue_side as the egress model.
*/
`timescale 1ns/1ps
module frame_buffer_admission_qos_tb;
  import qos_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic arr_valid = 1'b0;
  logic arr_ok;
  cls_type cls = '0;
  adm_type adm;
  rel_type rel = '0;
  logic [NPORT-1:0] xoff;
  logic mc_xoff;
  logic [NQ-1:0] upq_nonempty;
  logic sched_req = 1'b0;
  logic [NQ-1:0] upq_grant;
  logic [NACC-1:0] rx_use = '0;
  logic [NACC-1:0] tx_use = '0;
  logic [NACC-1:0] rx_allow;
  logic [NACC-1:0] tx_allow;
  logic load_valid = 1'b0;
  logic [1:0] load_q = 2'h0;
  logic [6:0] adm_q[$];
  logic [31:0] rd_q[$];
  logic [NQ-1:0] gnt_q[$];
  logic rd_prev = 1'b0;
  int fail_count = 0;
  int checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  buffer_qos #(.SHAPE_CAP(128)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_valid(arr_valid),
    .arr_ok(arr_ok), .cls(cls), .adm(adm), .rel(rel), .xoff(xoff),
    .mc_xoff(mc_xoff), .upq_nonempty(upq_nonempty),
    .sched_req(sched_req), .upq_grant(upq_grant), .rx_use(rx_use),
    .tx_use(tx_use), .rx_allow(rx_allow), .tx_allow(tx_allow));
  queue_side qside (.sys_clk(sys_clk), .resetn(resetn),
    .load_valid(load_valid), .load_q(load_q), .upq_grant(upq_grant),
    .upq_nonempty(upq_nonempty));
  task automatic chk(input string w, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Monitor: notes are taken oldest first as results appear
  always @(negedge sys_clk) begin
    logic [6:0] n;
    if (adm.valid === 1'b1) begin
      n = adm_q.size() != 0 ? adm_q.pop_front() : 7'h7F;
      chk("adm", 32'(n[5:3]), {adm.drop, n[5] ? 2'b00 : adm.region});
      if (n[6]) chk("queue", 32'(n[1:0]), 32'(adm.queue));
    end
    if (rd_prev) chk("rdata", rd_q.size() != 0 ? rd_q.pop_front() : 0,
      reg_rdata);
    if (upq_grant !== 4'h0) chk("grant",
      gnt_q.size() != 0 ? 32'(gnt_q.pop_front()) : 0, 32'(upq_grant));
    rd_prev = reg_rd;
  end
  function automatic logic [6:0] note(input logic q, input logic d,
    input region_type r);
    return {q, d, d ? 2'b00 : r, 3'b000};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // Arrival first, switch response next cycle; qdepth stays uncongested
  task automatic send(input logic [3:0] s, input logic [2:0] p,
    input logic m, input logic [6:0] n);
    adm_q.push_back(n);
    @(posedge sys_clk);
    arr_valid <= 1'b1;
    @(posedge sys_clk);
    arr_valid <= 1'b0;
    cls <= '{1'b1, s, p, m, 12'($urandom_range(0, 4094))};
    @(posedge sys_clk);
    cls.valid <= 1'b0;
  endtask
  task automatic free(input region_type r, input logic [3:0] s,
    input logic m);
    @(posedge sys_clk);
    rel <= '{1'b1, r, s, 3'h0, m};
    @(posedge sys_clk);
    rel.valid <= 1'b0;
  endtask
  // Waits only; the caller samples the level once it has settled
  task automatic look();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    $display("BAD timeout expected done seen hang");
    close_out();
  end
  initial begin
    void'($urandom(32'hecd1668c));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFS_TEMP, 32'(TEMP_RST));
    rd(OFS_SHARED, 32'(SHARED_RST));
    rd(OFS_ACC, 32'(RES_RST));
    rd(OFS_CPU, 32'(RES_RST));
    rd(8'hFC, 32'h0);
    wr(OFS_ST_SHARED, 32'hFFFF);
    rd(OFS_ST_SHARED, 32'h0);
    #1 chk("arr_ok", 32'h1, 32'(arr_ok));
    $display("test registers done");
    wr(OFS_CLASS, 32'h1);
    wr(OFS_SHARED, 32'h1);
    wr(OFS_PKT, 32'hFFF);
    wr(OFS_CTRL, 32'h1 << (CTRL_PAUSE_LSB + 2));
    wr(OFS_XOFF, 32'h4);
    wr(OFS_MCH, 32'h2);
    wr(OFS_MCP, 32'h1);
    send(0, 0, 0, note(0, 0, REG_SHARED));
    send(0, 2, 0, note(0, 0, REG_CLASS));
    send(0, 3, 0, note(0, 0, REG_SOURCE));
    for (int i = 0; i < 8; i++) send(1, 0, 0, note(0, 0, REG_SOURCE));
    send(1, 0, 0, note(0, 1, REG_NONE));
    rd(OFS_ST_SRC + 8'h04, 32'h8);
    free(REG_SOURCE, 1, 0);
    rd(OFS_ST_SRC + 8'h04, 32'h7);
    send(1, 0, 0, note(0, 0, REG_SOURCE));
    $display("test admission done");
    send(2, 6, 0, note(1, 0, REG_SOURCE));
    for (int i = 0; i < 2; i++) send(2, 0, 0, note(0, 0, REG_SOURCE));
    look();
    chk("xoff early", 32'h0, 32'(xoff[2]));
    send(2, 0, 0, note(0, 0, REG_SOURCE));
    look();
    chk("xoff set", 32'h1, 32'(xoff[2]));
    for (int i = 0; i < 3; i++) free(REG_SOURCE, 2, 0);
    look();
    chk("xoff held", 32'h1, 32'(xoff[2]));
    free(REG_SOURCE, 2, 0);
    look();
    chk("xoff clear", 32'h0, 32'(xoff[2]));
    $display("test pause done");
    for (int i = 0; i < 2; i++) send(3, 0, 1, note(0, 0, REG_SOURCE));
    look();
    chk("mc_xoff set", 32'h1, 32'(mc_xoff));
    send(3, 0, 1, note(0, 1, REG_NONE));
    free(REG_SOURCE, 3, 1);
    look();
    chk("mc_xoff clear", 32'h0, 32'(mc_xoff));
    $display("test multicast done");
    gnt_q.delete();
    gnt_q.push_back(4'h8);
    gnt_q.push_back(4'h2);
    gnt_q.push_back(4'h2);
    gnt_q.push_back(4'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      load_valid <= 1'b1;
      load_q <= i == 0 ? 2'h3 : (i == 3 ? 2'h0 : 2'h1);
    end
    @(posedge sys_clk);
    load_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sched_req <= 1'b1;
      @(posedge sys_clk);
      sched_req <= 1'b0;
      @(posedge sys_clk);
    end
    wr(OFS_SHAPE, 32'h0000_007F);
    rd(OFS_SHAPE, 32'h0000_0040);
    wr(OFS_SHAPE + 8'h04, 32'h0000_0020);
    wr(OFS_CTRL, 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      load_valid <= 1'b1;
      load_q <= 2'h1;
    end
    @(posedge sys_clk);
    load_valid <= 1'b0;
    // Half rate: full credit pays two grants, the third must wait
    sched_req <= 1'b1;
    gnt_q.push_back(4'h2);
    gnt_q.push_back(4'h2);
    repeat (3) @(posedge sys_clk);
    sched_req <= 1'b0;
    $display("test scheduler done");
    wr(OFS_RATE, {16'h0002, 8'h00, 8'h01});
    #1 chk("rx_allow empty", 32'h0, 32'(rx_allow[0]));
    // Lock onto the refill tick so later uses cannot straddle one
    for (int i = 0; i < 300 && rx_allow[0] !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("rx_allow", 32'h1, 32'(rx_allow[0]));
    chk("tx_allow", 32'h0, 32'(tx_allow[0]));
    repeat (450) @(posedge sys_clk);
    rx_use[0] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rx_use[0] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("rx_allow burst", 32'h0, 32'(rx_allow[0]));
    $display("test rate done");
    for (int i = 0; i < 20; i++) begin
      if (adm_q.size() + rd_q.size() + gnt_q.size() != 0) begin
        @(posedge sys_clk);
      end
    end
    chk("pending", 32'h0, adm_q.size() + rd_q.size() + gnt_q.size());
    close_out();
  end
endmodule
